// >>> hw/ipg_pkg.sv
// Package for the interpacket gap access timer: register map, field positions, cycle counts.
// Assumes a 20 MHz ref_clk and an AXI4-Lite master with 32-bit data.
package ipg_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PAD = 8'h04;
    localparam logic [7:0] REG_INDET = 8'h08;
    localparam logic [7:0] REG_MINGAP = 8'h0c;
    localparam logic [7:0] REG_SLOTW = 8'h10;
    localparam logic [7:0] REG_SLOTS = 8'h14;
    localparam logic [7:0] REG_BITW = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;
    // Control fields
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_EN = 2;
    localparam int CTRL_TXREQ = 3;
    localparam int CTRL_RXDONE = 4;
    localparam int CTRL_TXDONE = 5;
    // Mode encodings
    localparam logic [1:0] MODE_DIFF = 2'h0;
    localparam logic [1:0] MODE_SE = 2'h1;
    localparam logic [1:0] MODE_SP = 2'h2;
    // Processor handling times in ref_clk cycles; activity hold in bit times
    localparam logic [15:0] POST_TX_WIRE = 16'd313;
    localparam logic [15:0] POST_TX_SP = 16'd307;
    localparam logic [15:0] POST_RX_WIRE = 16'd295;
    localparam logic [15:0] POST_RX_SP = 16'd285;
    localparam logic [15:0] PRE_WIRE = 16'd270;
    localparam logic [15:0] PRE_SP = 16'd317;
    localparam logic [15:0] ACT_HOLD_BITS = 16'd3;
    // Processor minor cycle of 300 ns at a 20 MHz MAC clock
    localparam int unsigned MINOR_NS = 300;
    localparam int unsigned MINOR_CYC_I = (MINOR_NS * (CLK_HZ / 1000000)) / 1000;
    localparam logic [15:0] MINOR_CYC = MINOR_CYC_I[15:0];
    // Reset values
    localparam logic [15:0] PAD_RST = 16'h0010;
    localparam logic [15:0] INDET_RST = 16'h0008;
    localparam logic [15:0] MINGAP_RST = 16'h0020;
    localparam logic [15:0] SLOTW_RST = 16'h0010;
    localparam logic [7:0] SLOTS_RST = 8'h10;
    localparam logic [15:0] BITW_RST = 16'h0010;
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_POST = 9'h002,
        ST_PAD = 9'h004,
        ST_IDLEWAIT = 9'h008,
        ST_PRE = 9'h010,
        ST_COUNT = 9'h020,
        ST_MINGAP = 9'h040,
        ST_START = 9'h080,
        ST_TX = 9'h100
    } ipg_state_t;
endpackage

// >>> hw/ipg_access_timer.sv
// Interpacket gap sequencer with an AXI4-Lite register slave.
// Assumes line inputs synchronous to ref_clk; one write and one read in flight at a time.
`timescale 1ns/100ps
`default_nettype none
module ipg_access_timer
    import ipg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic line_rx,
    input wire logic rx_valid_bit,
    input wire logic sp_busy,
    input wire logic sp_tx_refuse,
    output logic tx_enable,
    output logic tx_data,
    output logic sync_qual_en,
    output logic sp_tx_req
);
    ipg_state_t state_q;
    logic [15:0] cnt_q;
    logic [7:0] slot_q;
    logic [15:0] gap_q;
    logic gap_run_q;
    logic [1:0] mode_q;
    logic en_q;
    logic tx_pend_q;
    logic last_tx_q;
    logic pkt_done_q;
    logic [15:0] pad_q, indet_q, mingap_q, slotw_q, bitw_q;
    logic [7:0] slots_q;
    logic [15:0] lfsr_q;
    logic line_q;
    logic [15:0] act_q;
    logic activity;
    logic aw_got_q, w_got_q;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    logic refused_q;
    logic wired;
    logic sending;

    assign wired = (mode_q != MODE_SP);
    // Own transmission owns the line from the start request on
    assign sending = (state_q == ST_START) || (state_q == ST_TX);

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic [15:0] post_cycles(input logic was_tx, input logic w);
        if (was_tx)
            post_cycles = w ? POST_TX_WIRE : POST_TX_SP;
        else
            post_cycles = w ? POST_RX_WIRE : POST_RX_SP;
    endfunction

    // Activity detect: any transition held three bit times in wired modes
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            line_q <= 1'b0;
            act_q <= 16'h0000;
        end else begin
            line_q <= line_rx;
            if (wired && (line_rx != line_q))
                act_q <= 16'(ACT_HOLD_BITS * bitw_q);
            else if (act_q != 16'h0000)
                act_q <= act_q - 16'h0001;
        end
    end
    // Special mode relies on the transceiver's busy line
    assign activity = wired ? ((line_rx != line_q) || (act_q != 16'h0000)) : sp_busy;

    // Bit-sync qualification enabled by valid bits, held off while sending
    always_ff @(posedge ref_clk) begin
        if (sys_rst)
            sync_qual_en <= 1'b0;
        else
            sync_qual_en <= rx_valid_bit && !sending;
    end

    // Random slot source
    always_ff @(posedge ref_clk) begin
        if (sys_rst)
            lfsr_q <= 16'hace1;
        else
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end

    // Minimum gap timer from end of code violation, independent of phases
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gap_q <= 16'h0000;
            gap_run_q <= 1'b0;
        end else if (pkt_done_q) begin
            gap_q <= mingap_q;
            gap_run_q <= 1'b1;
        end else if (gap_q != 16'h0000) begin
            gap_q <= gap_q - 16'h0001;
        end else begin
            gap_run_q <= 1'b0;
        end
    end

    // Gap sequencer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            slot_q <= 8'h00;
            tx_enable <= 1'b0;
            tx_data <= 1'b0;
            sp_tx_req <= 1'b0;
            refused_q <= 1'b0;
        end else if (!en_q) begin
            state_q <= ST_IDLE;
            tx_enable <= 1'b0;
            sp_tx_req <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (pkt_done_q) begin
                        state_q <= ST_POST;
                        // Allow one minor cycle of packet-end skew
                        cnt_q <= post_cycles(last_tx_q, wired) + MINOR_CYC;
                    end else if (tx_pend_q) begin
                        state_q <= ST_IDLEWAIT;
                        cnt_q <= slotw_q;
                    end
                end
                ST_POST: begin
                    if (cnt_q <= 16'h0001) begin
                        state_q <= ST_PAD;
                        // Padding covers indeterminate time plus three bits in wired modes
                        cnt_q <= pad_q + indet_q + (wired ? 16'(ACT_HOLD_BITS * bitw_q) : 16'h0000);
                    end else
                        cnt_q <= cnt_q - 16'h0001;
                end
                ST_PAD: begin
                    if (cnt_q <= 16'h0001) begin
                        state_q <= tx_pend_q ? ST_IDLEWAIT : ST_IDLE;
                        cnt_q <= slotw_q;
                    end else
                        cnt_q <= cnt_q - 16'h0001;
                end
                ST_IDLEWAIT: begin
                    if (activity)
                        cnt_q <= slotw_q;
                    else if (cnt_q <= 16'h0001) begin
                        state_q <= ST_PRE;
                        cnt_q <= wired ? PRE_WIRE : PRE_SP;
                        slot_q <= lfsr_q[7:0] % (slots_q == 8'h00 ? 8'h01 : slots_q);
                    end else
                        cnt_q <= cnt_q - 16'h0001;
                end
                ST_PRE: begin
                    if (cnt_q <= 16'h0001) begin
                        state_q <= ST_COUNT;
                        cnt_q <= slotw_q;
                    end else
                        cnt_q <= cnt_q - 16'h0001;
                end
                ST_COUNT: begin
                    if (activity) begin
                        // Earlier slot taken by another node: recheck idle
                        state_q <= ST_IDLEWAIT;
                        cnt_q <= slotw_q;
                    end else if (slot_q == 8'h00)
                        state_q <= ST_MINGAP;
                    else if (cnt_q <= 16'h0001) begin
                        slot_q <= slot_q - 8'h01;
                        cnt_q <= slotw_q;
                    end else
                        cnt_q <= cnt_q - 16'h0001;
                end
                ST_MINGAP: begin
                    // Gap timer runs apart from the phases, so a late slot waits no longer
                    if (!gap_run_q || gap_q == 16'h0000) begin
                        state_q <= ST_START;
                        if (wired) begin
                            tx_enable <= 1'b1;
                            tx_data <= ~line_q;
                        end else
                            sp_tx_req <= 1'b1;
                    end
                end
                ST_START: begin
                    // Start completes within one clock, well inside a bit time
                    if (!wired && sp_tx_refuse) begin
                        // Request stays pending so the sequence retries
                        state_q <= ST_IDLEWAIT;
                        sp_tx_req <= 1'b0;
                        refused_q <= 1'b1;
                        cnt_q <= slotw_q;
                    end else
                        state_q <= ST_TX;
                end
                ST_TX: begin
                    if (pkt_done_q) begin
                        state_q <= ST_POST;
                        tx_enable <= 1'b0;
                        sp_tx_req <= 1'b0;
                        refused_q <= 1'b0;
                        cnt_q <= post_cycles(last_tx_q, wired) + MINOR_CYC;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // AXI4-Lite write channel
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h00000000;
            ws_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            // Ready pulses once per beat, held off while a response waits
            s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
            s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (aw_got_q && w_got_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_q[7:2] <= REG_STATUS[7:2] && aw_q[7:2] != REG_STATUS[7:2]) ? 2'h0 : 2'h2;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Configuration registers written by software
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_q <= MODE_DIFF;
            en_q <= 1'b0;
            pad_q <= PAD_RST;
            indet_q <= INDET_RST;
            mingap_q <= MINGAP_RST;
            slotw_q <= SLOTW_RST;
            slots_q <= SLOTS_RST;
            bitw_q <= BITW_RST;
            tx_pend_q <= 1'b0;
            pkt_done_q <= 1'b0;
            last_tx_q <= 1'b0;
        end else begin
            // Done strobe lasts one cycle
            pkt_done_q <= 1'b0;
            if (state_q == ST_START && !(!wired && sp_tx_refuse))
                tx_pend_q <= 1'b0;
            if (aw_got_q && w_got_q && !s_axi_bvalid) begin
                case ({aw_q[7:2], 2'b00})
                    REG_CTRL: begin
                        if (ws_q[0]) begin
                            mode_q <= w_q[CTRL_MODE_LO +: 2];
                            en_q <= w_q[CTRL_EN];
                            if (w_q[CTRL_TXREQ])
                                tx_pend_q <= 1'b1;
                            pkt_done_q <= w_q[CTRL_RXDONE] | w_q[CTRL_TXDONE];
                            // Direction of the finished packet picks the handling time
                            last_tx_q <= w_q[CTRL_TXDONE];
                        end
                    end
                    REG_PAD: pad_q <= merge16(pad_q, w_q, ws_q);
                    REG_INDET: indet_q <= merge16(indet_q, w_q, ws_q);
                    REG_MINGAP: mingap_q <= merge16(mingap_q, w_q, ws_q);
                    REG_SLOTW: begin
                        // Slot written narrower than the current bit width is raised to it; a later bit width write does not re-check
                        if (merge16(slotw_q, w_q, ws_q) < bitw_q)
                            slotw_q <= bitw_q;
                        else
                            slotw_q <= merge16(slotw_q, w_q, ws_q);
                    end
                    REG_SLOTS: if (ws_q[0]) slots_q <= w_q[7:0];
                    REG_BITW: bitw_q <= merge16(bitw_q, w_q, ws_q);
                    default: ;
                endcase
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= 1'b0;
            // Address taken and answer raised together; next read waits for rready
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case ({s_axi_araddr[7:2], 2'b00})
                    REG_CTRL: s_axi_rdata <= {26'h0, 1'b0, 1'b0, tx_pend_q, en_q, mode_q};
                    REG_PAD: s_axi_rdata <= {16'h0, pad_q};
                    REG_INDET: s_axi_rdata <= {16'h0, indet_q};
                    REG_MINGAP: s_axi_rdata <= {16'h0, mingap_q};
                    REG_SLOTW: s_axi_rdata <= {16'h0, slotw_q};
                    REG_SLOTS: s_axi_rdata <= {24'h0, slots_q};
                    REG_BITW: s_axi_rdata <= {16'h0, bitw_q};
                    REG_STATUS: s_axi_rdata <= {13'h0, refused_q, activity, state_q, slot_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> verif/ipg_access_timer_monitor.sv
// Checker for the gap sequencer: bus answers and line-side outputs.
// Bound onto ipg_access_timer; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module ipg_access_timer_monitor
    import ipg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic line_rx,
    input wire logic rx_valid_bit,
    input wire logic tx_enable,
    input wire logic tx_data,
    input wire logic sync_qual_en,
    input wire logic sp_tx_req
);
    default clocking mon_cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_wr_okay: assert property (wr_taken ##0 (s_axi_awaddr < REG_STATUS) |-> ##[1:3]
        (s_axi_bvalid && s_axi_bresp == 2'h0)) else $error("mapped write not answered okay");
    a_status_ro: assert property (wr_taken ##0 (s_axi_awaddr == REG_STATUS) |-> ##[1:3]
        (s_axi_bvalid && s_axi_bresp == 2'h2)) else $error("status write not refused");
    a_rd_answer: assert property (rd_taken |-> ##[0:1] s_axi_rvalid)
        else $error("read not answered");
    a_unmapped_rd: assert property (rd_taken ##0 (s_axi_araddr[7:2] > REG_STATUS[7:2]) |-> ##[0:1]
        (s_axi_rvalid && s_axi_rresp == 2'h2)) else $error("unmapped read not refused");
    a_sync_follow: assert property (!tx_enable && !sp_tx_req && !$past(tx_enable) && !$past(sp_tx_req)
        |-> sync_qual_en == $past(rx_valid_bit)) else $error("sync qualify does not follow valid bits");
    a_sync_off_tx: assert property (tx_enable && $past(tx_enable) |-> !sync_qual_en)
        else $error("sync qualify active while sending");
    a_one_mode: assert property (!(tx_enable && sp_tx_req))
        else $error("wired and special transmit both active");
    a_first_edge: assert property ($rose(tx_enable) |-> tx_data != line_rx)
        else $error("first level not inverse of line");
    c_start: cover property ($rose(tx_enable));
endmodule
bind ipg_access_timer ipg_access_timer_monitor ipg_access_timer_monitor_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .line_rx(line_rx), .rx_valid_bit(rx_valid_bit), .tx_enable(tx_enable), .tx_data(tx_data),
    .sync_qual_en(sync_qual_en), .sp_tx_req(sp_tx_req)
);
`default_nettype wire

// >>> verif/ipg_line_partner.sv
// Model of the channel side: other nodes and the line transceiver.
// A pulse on act_req makes one short burst of line transitions.
`timescale 1ns/100ps
`default_nettype none
module ipg_line_partner (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic act_req,
    output logic line_rx,
    output logic rx_valid_bit,
    output logic sp_busy,
    output logic sp_tx_refuse
);
    logic [3:0] burst_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            burst_q <= 4'h0;
            line_rx <= 1'b0;
            rx_valid_bit <= 1'b0;
        end else if (act_req) begin
            burst_q <= 4'h8;
        end else if (burst_q != 4'h0) begin
            burst_q <= burst_q - 4'h1;
            line_rx <= ~line_rx;
            rx_valid_bit <= burst_q[0];
        end else begin
            rx_valid_bit <= 1'b0;
        end
    end
    assign sp_busy = burst_q != 4'h0;
    // Transceiver refuses a start while it sees the channel busy
    assign sp_tx_refuse = sp_busy;
endmodule
`default_nettype wire

// >>> verif/ipg_access_timer_bench.sv
// Self-checking bench for the gap sequencer over its register bus.
// Assumes ipg_pkg, the line partner and the bound monitor are compiled.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module ipg_access_timer_bench
    import ipg_pkg::*;
;
    localparam logic [31:0] RV [6] = '{32'(PAD_RST), 32'(INDET_RST), 32'(MINGAP_RST), 32'(SLOTW_RST),
        32'(SLOTS_RST), 32'(BITW_RST)};
    localparam logic [1:0] MD [4] = '{MODE_DIFF, MODE_SE, MODE_SP, MODE_SP};
    logic ref_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, act;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, sp;
    logic line_rx, rx_valid_bit, sp_busy, sp_tx_refuse, tx_enable, tx_data, sync_qual_en, sp_tx_req;
    int fails, n_tests, n, lo;
    ipg_access_timer ipg_access_timer_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .line_rx(line_rx), .rx_valid_bit(rx_valid_bit), .sp_busy(sp_busy), .sp_tx_refuse(sp_tx_refuse),
        .tx_enable(tx_enable), .tx_data(tx_data), .sync_qual_en(sync_qual_en), .sp_tx_req(sp_tx_req));
    ipg_line_partner ipg_line_partner_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .act_req(act),
        .line_rx(line_rx), .rx_valid_bit(rx_valid_bit), .sp_busy(sp_busy), .sp_tx_refuse(sp_tx_refuse));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= dv;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        `CHK(bresp, er)
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dq, output logic [1:0] rq);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        dq = rdata;
        rq = rresp;
        rready <= 1'b0;
    endtask
    task automatic run(input logic s, output int c);
        c = 0;
        do begin
            @(posedge ref_clk);
            c++;
        end while (!(s ? sp_tx_req : tx_enable) && c < 3000);
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        give_verdict();
    end
    initial begin
        {sys_rst, awvalid, wvalid, bready, arvalid, rready, act} = 7'h40;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(REG_PAD + 8'(4 * i), d, r);
            `CHK(d, RV[i])
        end
        rd(8'h20, d, r);
        `CHK(r, 2'h2)
        wr(REG_STATUS, 32'h0, 2'h2);
        wr(REG_PAD, 32'h4, 2'h0);
        wr(REG_INDET, 32'h4, 2'h0);
        wr(REG_MINGAP, 32'h0, 2'h0);
        wr(REG_SLOTS, 32'h1, 2'h0);
        wr(REG_SLOTW, 32'h4, 2'h0);
        rd(REG_SLOTW, d, r);
        `CHK(d, 32'h10)
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            sp = i >= 2;
            wr(REG_CTRL, 32'(MD[i]) | ((i % 2) ? 32'h1c : 32'h2c), 2'h0);
            rd(REG_STATUS, d, r);
            `CHK(d[16:8], ST_POST)
            `CHK({tx_enable, sp_tx_req}, 2'b00)
            run(sp, n);
            lo = sp ? ((i % 2) ? POST_RX_SP : POST_TX_SP) + PRE_SP : ((i % 2) ? POST_RX_WIRE : POST_TX_WIRE) + 48;
            lo = lo + (sp ? 24 : 24 + PRE_WIRE);
            `CHK((n >= lo - 10) && (n <= lo + 40), 1'b1)
        end
        $display("test handling times done");
        wr(REG_SLOTW, 32'd200, 2'h0);
        wr(REG_CTRL, 32'h2c, 2'h0);
        repeat (450) @(posedge ref_clk);
        act <= 1'b1;
        @(posedge ref_clk);
        act <= 1'b0;
        run(1'b0, n);
        `CHK((n + 451 >= 958) && (n + 451 <= 1030), 1'b1)
        act <= 1'b1;
        @(posedge ref_clk);
        act <= 1'b0;
        repeat (4) @(posedge ref_clk);
        `CHK(sync_qual_en, 1'b0)
        $display("test idle wait done");
        wr(REG_SLOTW, 32'h10, 2'h0);
        wr(REG_MINGAP, 32'd1500, 2'h0);
        for (int j = 0; j < 2; j++) begin
            wr(REG_CTRL, 32'(MD[j]) | 32'h2c, 2'h0);
            run(1'b0, n);
            `CHK((n >= 1488) && (n <= 1545), 1'b1)
        end
        $display("test minimum gap done");
        wr(REG_CTRL, 32'(MODE_SP) | 32'h2c, 2'h0);
        repeat (1496) @(posedge ref_clk);
        act <= 1'b1;
        @(posedge ref_clk);
        act <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rd(REG_STATUS, d, r);
        `CHK(d[18], 1'b1)
        `CHK(d[16:8], ST_IDLEWAIT)
        run(1'b1, n);
        `CHK((n >= 300) && (n <= 360), 1'b1)
        $display("test refused start done");
        give_verdict();
    end
endmodule
`default_nettype wire
